// >>> sar_cc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Conversion control port checks.
// ----------------------------------------
module sar_cc_assertions
  import sar_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 select_n,
  input wire logic                 shift_clock,
  input wire logic                 comp_high,
  input wire logic                 over_range,
  input wire logic                 under_range,
  input wire logic [15:0]          dac_bits,
  input wire sar_pkg::analog_ctl_s analog_ctl,
  input wire logic                 sdo_out,
  input wire logic                 sdo_oe,
  input wire logic                 busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_conv; busy [*8] ##1 busy [*8] ##1 busy [*3] ##1 !busy; endsequence
  sequence s_acq; analog_ctl.array_to_input && analog_ctl.pos_array_ground_switch; endsequence
  property p_start; $fell(select_n) |-> ##[2:6] busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_conv; $rose(busy) |-> s_conv; endproperty
  a_conv: assert property (p_conv) else $error("bad length");
  property p_gnd; $rose(analog_ctl.array_to_ground) |->
    !$past(analog_ctl.pos_array_ground_switch) && !$past(analog_ctl.neg_array_ground_switch); endproperty
  a_gnd: assert property (p_gnd) else $error("switch order");
  property p_excl; !(analog_ctl.array_to_input && analog_ctl.array_to_ground); endproperty
  a_excl: assert property (p_excl) else $error("array overlap");
  property p_msb; $rose(analog_ctl.array_to_ground) |-> ##[0:3] dac_bits == 16'h8000; endproperty
  a_msb: assert property (p_msb) else $error("no msb trial");
  property p_acq; $fell(busy) |-> ##[0:2] s_acq; endproperty
  a_acq: assert property (p_acq) else $error("no acquire");
  property p_pwr; (!busy) [*3] |-> !analog_ctl.powered; endproperty
  a_pwr: assert property (p_pwr) else $error("powered idle");
  property p_hiz; select_n [*5] |-> !sdo_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("driven idle");
  property p_oe; (!select_n) [*6] |-> sdo_oe; endproperty
  a_oe: assert property (p_oe) else $error("not driven");
endmodule : sar_cc_assertions
bind sar_conversion_control sar_cc_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk(mclk), .arst_n(arst_n),
  .select_n(select_n), .shift_clock(shift_clock), .comp_high(comp_high), .over_range(over_range),
  .under_range(under_range), .dac_bits(dac_bits), .analog_ctl(analog_ctl), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .busy(busy));
`default_nettype wire

// >>> sar_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_control #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire logic               select_n,
  input  wire logic               shift_clock,
  input  wire logic               comp_high,
  input  wire logic               over_range,
  input  wire logic               under_range,
  output var  logic [15:0]        dac_bits,
  output var  sar_pkg::analog_ctl_s analog_ctl,
  output var  logic               sdo_out,
  output var  logic               sdo_oe,
  output var  logic               busy
);
  import sar_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_depth_check
    $error("FIFO_DEPTH must be at least 2");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sel_sync_q, sclk_sync_q;
  logic       sel_lvl_q, sel_lvl_d, sclk_lvl_q, sclk_lvl_d;
  logic       sel_fall, sel_rise, sclk_fall;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_sync_q  <= 3'h7;
      sclk_sync_q <= 3'h7;
      sel_lvl_q   <= 1'b1;
      sclk_lvl_q  <= 1'b1;
    end else begin
      sel_sync_q  <= {sel_sync_q[1:0], select_n};
      sclk_sync_q <= {sclk_sync_q[1:0], shift_clock};
      sel_lvl_q   <= sel_lvl_d;
      sclk_lvl_q  <= sclk_lvl_d;
    end
  end

  // A level change counts only once the last two stages agree on it.
  always_comb begin
    sel_fall   = (sel_sync_q[2:1] == 2'b00) && sel_lvl_q;
    sel_rise   = (sel_sync_q[2:1] == 2'b11) && !sel_lvl_q;
    sclk_fall  = (sclk_sync_q[2:1] == 2'b00) && sclk_lvl_q;
    sel_lvl_d  = sel_fall ? 1'b0 : (sel_rise ? 1'b1 : sel_lvl_q);
    sclk_lvl_d = (sclk_sync_q[2:1] == 2'b11) ? 1'b1 : (sclk_fall ? 1'b0 : sclk_lvl_q);
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  conv_state_e     st_q, st_d;
  logic [15:0]     trial_q, trial_d;
  logic [15:0]     bit_q, bit_d;
  logic [15:0]     res_d;
  logic            res_valid;
  logic            res_ready;
  analog_ctl_s     ctl_d;

  always_comb begin
    st_d      = st_q;
    trial_d   = trial_q;
    bit_d     = bit_q;
    res_d     = trial_q;
    res_valid = 1'b0;
    case (st_q)
      ST_ACQ: begin
        if (sel_fall && res_ready) begin
          st_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        st_d = ST_GROUND;
      end
      ST_GROUND: begin
        st_d    = ST_TRIAL;
        bit_d   = 16'h8000;
        trial_d = 16'h8000;
      end
      ST_TRIAL: begin
        if (comp_high) begin
          trial_d = trial_q & ~bit_q;
        end
        bit_d = bit_q >> 1;
        if (bit_q[0]) begin
          st_d = ST_DONE;
        end else begin
          trial_d = (comp_high ? (trial_q & ~bit_q) : trial_q) | (bit_q >> 1);
        end
      end
      ST_DONE: begin
        res_valid = 1'b1;
        if (over_range) begin
          res_d = CODE_FULL;
        end else if (under_range) begin
          res_d = CODE_ZERO;
        end else begin
          res_d = trial_q;
        end
        st_d = ST_ACQ;
      end
      default: begin
        st_d = ST_ACQ;
      end
    endcase
  end

  always_comb begin
    ctl_d.pos_array_ground_switch = (st_d == ST_ACQ);
    ctl_d.neg_array_ground_switch = (st_d == ST_ACQ);
    ctl_d.array_to_input          = (st_d == ST_ACQ) || (st_d == ST_OPEN);
    ctl_d.array_to_ground         = (st_d == ST_GROUND) || (st_d == ST_TRIAL);
    ctl_d.powered                 = (st_d != ST_ACQ);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= ST_ACQ;
      trial_q <= 16'h0000;
      bit_q   <= 16'h0000;
    end else begin
      st_q    <= st_d;
      trial_q <= trial_d;
      bit_q   <= bit_d;
    end
  end

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  logic [15:0] fifo_data;
  logic        fifo_valid, fifo_pop;

  sar_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_data   (res_d),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  logic [4:0]  falls_q, falls_d;
  logic [15:0] shreg_q, shreg_d;
  logic        loaded_q, loaded_d;
  logic        sdo_d, oe_d;
  logic        framed_q, framed_d;

  always_comb begin
    falls_d  = falls_q;
    shreg_d  = shreg_q;
    loaded_d = loaded_q;
    framed_d = framed_q;
    sdo_d    = sdo_out;
    oe_d     = sdo_oe;
    fifo_pop = 1'b0;
    if (sel_rise) begin
      framed_d = 1'b0;
      oe_d     = 1'b0;
      loaded_d = 1'b0;
    end else if (sel_fall) begin
      framed_d = 1'b1;
      falls_d  = SHIFT_RESET;
      loaded_d = 1'b0;
      oe_d     = 1'b1;
    end else if (framed_q && sclk_fall) begin
      falls_d = (falls_q == 5'h1F) ? falls_q : falls_q + 5'h01;
      if (falls_q == 5'(LEAD_FALLS - 1)) begin
        sdo_d = 1'b0;
      end else if (falls_q >= 5'(LEAD_FALLS) && loaded_q) begin
        sdo_d   = shreg_q[15];
        shreg_d = {shreg_q[14:0], 1'b0};
      end
    end
    // The result of this frame's own conversion is picked up once ready, if that is before the sixth shift-clock fall.
    // A frame that ends now must not take a result, or the next frame would skip its own.
    if (framed_q && !sel_rise && !loaded_q && fifo_valid && falls_q <= 5'(LEAD_FALLS)) begin
      shreg_d  = fifo_data;
      loaded_d = 1'b1;
      fifo_pop = 1'b1;
    end
    if (!framed_q && fifo_valid) begin
      fifo_pop = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      falls_q  <= SHIFT_RESET;
      shreg_q  <= 16'h0000;
      loaded_q <= 1'b0;
      framed_q <= 1'b0;
      sdo_out  <= 1'b0;
      sdo_oe   <= 1'b0;
      dac_bits <= 16'h0000;
      analog_ctl <= 5'b11100;
      busy     <= 1'b0;
    end else begin
      falls_q  <= falls_d;
      shreg_q  <= shreg_d;
      loaded_q <= loaded_d;
      framed_q <= framed_d;
      sdo_out  <= sdo_d;
      sdo_oe   <= oe_d;
      dac_bits <= trial_d;
      analog_ctl <= ctl_d;
      busy     <= (st_d != ST_ACQ);
    end
  end
endmodule : sar_conversion_control
`default_nettype wire

// >>> sar_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Conversion control bench.
// ----------------------------------------
module sar_conversion_control_tb;
  import sar_pkg::*;
  logic        mclk, arst_n, comp_high, over_range, under_range, select_n, shift_clock;
  logic        sdo_out, sdo_oe, busy, lead;
  logic [15:0] dac_bits, tgt, word;
  analog_ctl_s actl;
  int          errors, n_tests;
  sar_conversion_control #(.FIFO_DEPTH(4)) u_dut (.mclk(mclk), .arst_n(arst_n), .select_n(select_n),
    .shift_clock(shift_clock), .comp_high(comp_high), .over_range(over_range), .under_range(under_range),
    .dac_bits(dac_bits), .analog_ctl(actl), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .busy(busy));
  sar_host_model u_host (.mclk(mclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .select_n(select_n),
    .shift_clock(shift_clock));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // The comparator flags a trial word above the held sample.
  always @(negedge mclk) comp_high <= dac_bits > tgt;
  function automatic logic [15:0] exp_code(logic [15:0] t, logic ov, logic un);
    return ov ? CODE_FULL : (un ? CODE_ZERO : t);
  endfunction : exp_code
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    errors++;
    stop_test;
  end
  initial begin
    arst_n = 1'b0; tgt = 16'h0000; over_range = 1'b0; under_range = 1'b0;
    void'($urandom(25376));
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 12; i++) begin
      tgt = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : (i == 2) ? 16'hFFFF : (i == 3) ? 16'h7FFF : 16'($urandom);
      over_range = (i == 4) || (i == 6);
      under_range = (i == 5) || (i == 6);
      if (i == 7) begin
        // A frame cut before its result is ready; its code must not reach the next frame.
        tgt = ~tgt;
        u_host.frame(word, lead, 1);
        tgt = ~tgt;
      end
      u_host.frame(word, lead, 21);
      check(16'(lead), 16'h0000);
      check(word, exp_code(tgt, over_range, under_range));
      check(dac_bits, tgt);
      @(negedge mclk);
      check(16'(sdo_oe), 16'h0000);
      check(16'(busy), 16'h0000);
      check(16'(actl), 16'h001C);
    end
    stop_test;
  end
endmodule : sar_conversion_control_tb
`default_nettype wire

// >>> sar_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  always_comb begin
    in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    out_valid = wr_q != rd_q;
    out_data  = mem_q[rd_q[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : sar_fifo
`default_nettype wire

// >>> sar_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial host driving select and shift clock.
// ----------------------------------------
module sar_host_model (
  input  wire logic mclk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  output var  logic select_n,
  output var  logic shift_clock
);
  logic pin;
  // A released line shows the inverse of its last value.
  assign pin = sdo_oe ? sdo_out : ~sdo_out;
  initial begin
    select_n    = 1'b1;
    shift_clock = 1'b1;
  end
  task automatic frame(output logic [15:0] word, output logic lead, input int n_falls);
    @(negedge mclk);
    #37 select_n = 1'b0;
    #800;
    for (int k = 1; k <= n_falls; k++) begin
      shift_clock = 1'b0;
      #400 shift_clock = 1'b1;
      #400;
      if (k == 5) lead = pin;
      else if (k > 5) word = {word[14:0], pin};
    end
    select_n = 1'b1;
    #1000;
  endtask : frame
endmodule : sar_host_model
`default_nettype wire

// >>> sar_pkg.sv
// Contract
// - A falling edge on the active-low select input starts a conversion and ends acquisition.
// - At conversion start the ground switches open first, then the arrays move from the inputs to ground.
// - A 16-bit successive approximation search decides one bit per trial from the MSB down.
// - When the search completes the block returns to acquisition and forms the output code.
// - The result is 16-bit straight binary, zero gives 0000 and midscale gives 8000.
// - An input above the reference saturates the code at FFFF.
// - An input below ground clamps the code to 0000.
// - The result sent belongs to the sample taken at that same conversion's start.
// - Conversions run up to 100 kSPS and the converter powers down between them.
// - The serial output is enabled at select's fall, is driven low after the fifth shift-clock fall, then gives bits MSB first.
// - While select is high the serial output is high impedance.
package sar_pkg;

  localparam int        RES_BITS       = 16;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_FULL    = 16'hFFFF;
  localparam int        CLK_HZ         = 10000000;
  localparam int        MAX_RATE_SPS   = 100000;
  localparam int        FRAME_CYCLES   = CLK_HZ / MAX_RATE_SPS;
  localparam int        LEAD_FALLS     = 5;
  localparam logic [4:0] SHIFT_RESET   = 5'h00;

  typedef enum logic [2:0] {
    ST_ACQ    = 3'b000,
    ST_OPEN   = 3'b001,
    ST_GROUND = 3'b010,
    ST_TRIAL  = 3'b011,
    ST_DONE   = 3'b100
  } conv_state_e;

  typedef struct packed {
    logic pos_array_ground_switch;
    logic neg_array_ground_switch;
    logic array_to_input;
    logic array_to_ground;
    logic powered;
  } analog_ctl_s;

endpackage : sar_pkg
